// file: hdl/rspm_defs.vh
/*
 * rspm_defs.vh: constants for the reset strap and async pin mux block.
 * assumes it is included by bare name from the design file.
 */
`ifndef RSPM_DEFS_VH
`define RSPM_DEFS_VH

// strap positions on the async address pads
`define RSPM_BOOT_SEL_HI 13
`define RSPM_BOOT_SEL_LO 12
`define RSPM_CFG_HI 11
`define RSPM_CFG_LO 8

// internal-pull defaults of the straps
`define RSPM_BOOT_SEL_DEF 2'h0
`define RSPM_CFG_DEF 4'hd

// boot source encodings
`define RSPM_BOOT_NAND 2'h0
`define RSPM_BOOT_ASYNC 2'h1
`define RSPM_BOOT_CARD 2'h2
`define RSPM_BOOT_UART 2'h3

// async pin configuration codes
`define RSPM_CFG_NAND 4'hd
`define RSPM_CFG_C 4'hc
`define RSPM_CFG_A 4'ha
`define RSPM_CFG_8 4'h8
`define RSPM_CFG_2 4'h2
`define RSPM_CFG_0 4'h0

// reset kinds reported on o_reset_kind
`define RSPM_RK_NONE 3'h0
`define RSPM_RK_POR 3'h1
`define RSPM_RK_WARM 3'h2
`define RSPM_RK_MAX 3'h3
`define RSPM_RK_SYS 3'h4
`define RSPM_RK_MOD 3'h5

// pad map: 16 upper pads (index 0 = highest address pad, 15 = a13) and 8 data pads
`define RSPM_NPAD 16
`define RSPM_NDATA 8

// default value of the other mux registers
`define RSPM_MUX_DEF 32'h0

// state codes
`define RSPM_ST_RESET 2'h0
`define RSPM_ST_SAMPLE 2'h1
`define RSPM_ST_RUN 2'h2

`endif

// file: hdl/rspm_top.v
/*
 * rspm_top.v: reset strap capture, reset classification and async memory pad mux.
 * assumes pad inputs are synchronous to i_clk and that the pads' own pulls give
 * the strap defaults when the board leaves them open.
 */
`timescale 1ns/1ps
`include "rspm_defs.vh"

// Notes on behaviour
// - latch config straps at reset, hold them
// - after sampling, pads return to memory function
// - boot select from address pads 13:12, default 00
// - decode boot select into four boot sources
// - pin config from address pads 11:8, default 1101
// - any rom boot drives boot progress pin
// - nand boot uses first chip select, serial port
// - async boot uses chip select; card boot card
// - config code governs pads in nand, async boots
// - code 1101 keeps only a1,a2; rest gpio
// - listed codes give bank1 and a0-a13 memory
// - top pad: a14, bank0 or gpio by code
// - a1 and a2 always memory pins
// - upper data byte only for 0010, 0000
// - five software mux registers override muxing
// - pin and test reset low: cold reset all
// - pin low, test high: warm, spare emulation
// - max reset equals warm reset; code leaves o_clock_power_rst_b released on max
// - system reset spares memory, emulation, clocks
// - software may reset single module, debug only
// - default configuration entered before boot starts
// - address run contiguous; others become gpio
module rspm_top #(
    parameter NMOD = 41
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // reset sources
    input wire i_test_rst_b,
    input wire i_max_rst_req,
    input wire i_sys_rst_req,
    input wire [NMOD-1:0] i_mod_rst_req,
    // strap pads (async address pads as seen during reset)
    input wire [13:0] i_async_addr_line,
    // software mux registers
    input wire i_mux_wr,
    input wire [2:0] i_mux_sel,
    input wire [31:0] i_mux_wdata,
    // boot status from firmware
    input wire i_boot_progress,
    // latched configuration
    output reg [1:0] o_boot_source_select,
    output reg [3:0] o_async_pin_config_code,
    output reg o_cfg_valid,
    // boot routing
    output reg o_boot_progress_pin,
    output reg o_boot_progress_pin_oe_b,
    output reg o_use_first_chip_select,
    output reg o_use_first_serial_port,
    output reg o_use_first_card_controller,
    output reg o_boot_from_rom,
    // pad functions: 1 = memory, 0 = gpio; o_top_pad_is_a14 1 = a14, 0 = bank0; o_strap_sample 1 = pads carry straps
    output reg o_async_bank_addr_line1_mem,
    output reg o_top_pad_mem,
    output reg o_top_pad_is_a14,
    output reg [13:0] o_async_addr_line_mem,
    output reg [7:0] o_async_data_line_hi_mem,
    output reg o_strap_sample,
    // software mux registers
    output reg [31:0] o_video_in_mux_reg,
    output reg [31:0] o_video_out_mux_reg,
    output reg [31:0] o_async_mem_mux_reg,
    output reg [31:0] o_gpio_mux_reg,
    output reg [31:0] o_serial_card_mux_reg,
    // reset outputs
    output reg [2:0] o_reset_kind,
    output reg o_module_rst_b,
    output reg o_memory_rst_b,
    output reg o_emulation_rst_b,
    output reg o_clock_power_rst_b,
    output reg [NMOD-1:0] o_mod_rst_b
);

////////////////////////////////////////////////////////////////////////////////
// pad decode from the active config code

function [25:0] rspm_pad_map;
    input [3:0] code;
    reg bank1;
    reg top;
    reg top14;
    reg [13:0] addr;
    reg [7:0] dhi;
    begin
        bank1 = 1'b0;
        top = 1'b0;
        top14 = 1'b0;
        addr = 14'h0006; // a1,a2 always memory
        dhi = 8'h00;
        case (code)
            `RSPM_CFG_NAND: begin
                addr = 14'h0006;
            end
            `RSPM_CFG_C: begin
                bank1 = 1'b1;
                addr = 14'h3fff;
            end
            `RSPM_CFG_A, `RSPM_CFG_2: begin
                bank1 = 1'b1;
                addr = 14'h3fff;
                top = 1'b1;
                top14 = 1'b1;
            end
            `RSPM_CFG_8, `RSPM_CFG_0: begin
                bank1 = 1'b1;
                addr = 14'h3fff;
                top = 1'b1; // bank-address bit 0
            end
            default: begin
                addr = 14'h0006; // unlisted codes fall back to gpio
            end
        endcase
        if (code == `RSPM_CFG_2 || code == `RSPM_CFG_0) begin
            dhi = 8'hff;
        end
        rspm_pad_map = {bank1, top, top14, addr, dhi, 1'b0};
    end
endfunction

// every boot select except direct async boot runs from the rom
function rspm_rom_boot;
    input [1:0] sel;
    begin
        rspm_rom_boot = (sel != `RSPM_BOOT_ASYNC);
    end
endfunction

// nand and direct async boot both fetch through the first chip select
function rspm_cs_boot;
    input [1:0] sel;
    begin
        rspm_cs_boot = (sel == `RSPM_BOOT_NAND) | (sel == `RSPM_BOOT_ASYNC);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// reset classification

wire por_rst_b;
reg [1:0] state;
reg [1:0] next_state;
reg pin_warm;
reg [2:0] next_kind;
wire [25:0] map;
wire in_run;
wire mux_take;

// a cold reset needs the pin and the test reset low together; the or of two
// slow levels is used as an async reset, so neither may glitch
assign por_rst_b = i_rst_b | i_test_rst_b;
assign map = rspm_pad_map(o_async_mem_mux_reg[3:0]);
assign in_run = (state == `RSPM_ST_RUN);
assign mux_take = in_run & i_mux_wr & ~i_max_rst_req;

// warm is only distinguishable while the clock still runs; the async reset of
// the core flops cannot tell it apart from por, so it is recorded here
always @(posedge i_clk or negedge i_test_rst_b) begin
    if (!i_test_rst_b) begin
        pin_warm <= 1'b0;
    end else begin
        pin_warm <= ~i_rst_b; // pin low with test high
    end
end

// emulation logic is cleared by a cold reset only
always @(posedge i_clk or negedge por_rst_b) begin
    if (!por_rst_b) begin
        o_emulation_rst_b <= 1'b0;
    end else begin
        o_emulation_rst_b <= 1'b1; // warm, max and system spare it
    end
end

always @* begin
    next_kind = `RSPM_RK_NONE;
    if (i_max_rst_req) begin
        next_kind = `RSPM_RK_MAX;
    end else if (i_sys_rst_req) begin
        next_kind = `RSPM_RK_SYS;
    end else if (|i_mod_rst_req) begin
        next_kind = `RSPM_RK_MOD;
    end
end

always @* begin
    case (state)
        `RSPM_ST_RESET: next_state = `RSPM_ST_SAMPLE;
        `RSPM_ST_SAMPLE: next_state = `RSPM_ST_RUN;
        `RSPM_ST_RUN: next_state = i_max_rst_req ? `RSPM_ST_SAMPLE : `RSPM_ST_RUN;
        default: next_state = `RSPM_ST_RESET;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// state and reset kind

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        state <= `RSPM_ST_RESET;
        o_reset_kind <= `RSPM_RK_POR;
    end else begin
        state <= next_state;
        if (state == `RSPM_ST_RESET) begin
            // the kind is only known once the pin has let go
            o_reset_kind <= pin_warm ? `RSPM_RK_WARM : `RSPM_RK_POR;
        end else if (next_kind != `RSPM_RK_NONE) begin
            o_reset_kind <= next_kind;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// strap capture

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_boot_source_select <= `RSPM_BOOT_SEL_DEF;
        o_async_pin_config_code <= `RSPM_CFG_DEF;
        o_cfg_valid <= 1'b0;
        o_strap_sample <= 1'b1;
    end else if (state == `RSPM_ST_SAMPLE) begin
        // straps are latched in every sample state (after reset and after a max reset), pads then go back to memory use
        o_boot_source_select <= i_async_addr_line[`RSPM_BOOT_SEL_HI:`RSPM_BOOT_SEL_LO];
        o_async_pin_config_code <= i_async_addr_line[`RSPM_CFG_HI:`RSPM_CFG_LO];
        o_strap_sample <= 1'b0;
        o_cfg_valid <= 1'b1;
    end else if (in_run && i_max_rst_req) begin
        // a max reset hands the pads back to the straps for a fresh sample
        o_cfg_valid <= 1'b0;
        o_strap_sample <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// software mux registers

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_video_in_mux_reg <= `RSPM_MUX_DEF;
        o_video_out_mux_reg <= `RSPM_MUX_DEF;
        o_async_mem_mux_reg <= {28'h0000000, `RSPM_CFG_DEF};
        o_gpio_mux_reg <= `RSPM_MUX_DEF;
        o_serial_card_mux_reg <= `RSPM_MUX_DEF;
    end else if (state == `RSPM_ST_SAMPLE) begin
        o_async_mem_mux_reg <= {28'h0000000,
            i_async_addr_line[`RSPM_CFG_HI:`RSPM_CFG_LO]};
        o_video_in_mux_reg <= `RSPM_MUX_DEF; // defaults before boot
        o_video_out_mux_reg <= `RSPM_MUX_DEF;
        o_gpio_mux_reg <= `RSPM_MUX_DEF;
        o_serial_card_mux_reg <= `RSPM_MUX_DEF;
    end else if (mux_take) begin
        // selects 5 to 7 are dropped silently
        case (i_mux_sel) // software override
            3'h0: o_video_in_mux_reg <= i_mux_wdata;
            3'h1: o_video_out_mux_reg <= i_mux_wdata;
            3'h2: o_async_mem_mux_reg <= i_mux_wdata;
            3'h3: o_gpio_mux_reg <= i_mux_wdata;
            3'h4: o_serial_card_mux_reg <= i_mux_wdata;
            default: o_video_in_mux_reg <= o_video_in_mux_reg;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// pad functions

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_async_bank_addr_line1_mem <= 1'b0;
        o_top_pad_mem <= 1'b0;
        o_top_pad_is_a14 <= 1'b0;
        o_async_addr_line_mem <= 14'h0006;
        o_async_data_line_hi_mem <= 8'h00;
    end else if (state != `RSPM_ST_RESET) begin
        // pad map lags the mux register by one cycle
        o_async_bank_addr_line1_mem <= map[25];
        o_top_pad_mem <= map[24];
        o_top_pad_is_a14 <= map[23];
        o_async_addr_line_mem <= map[22:9];
        o_async_data_line_hi_mem <= map[8:1];
    end
end

////////////////////////////////////////////////////////////////////////////////
// boot routing

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_boot_progress_pin <= 1'b0;
        o_boot_progress_pin_oe_b <= 1'b1;
        o_use_first_chip_select <= 1'b0;
        o_use_first_serial_port <= 1'b0;
        o_use_first_card_controller <= 1'b0;
        o_boot_from_rom <= 1'b0;
    end else if (o_cfg_valid) begin
        o_boot_from_rom <= rspm_rom_boot(o_boot_source_select);
        o_boot_progress_pin_oe_b <= ~rspm_rom_boot(o_boot_source_select);
        o_boot_progress_pin <= i_boot_progress;
        o_use_first_chip_select <= rspm_cs_boot(o_boot_source_select);
        o_use_first_serial_port <= (o_boot_source_select == `RSPM_BOOT_NAND);
        o_use_first_card_controller <= (o_boot_source_select == `RSPM_BOOT_CARD);
    end
end

////////////////////////////////////////////////////////////////////////////////
// reset outputs

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_module_rst_b <= 1'b0;
        o_memory_rst_b <= 1'b0;
        o_clock_power_rst_b <= 1'b0;
        o_mod_rst_b <= {NMOD{1'b0}};
    end else begin
        o_mod_rst_b <= ~i_mod_rst_req; // single module reset
        if (state == `RSPM_ST_SAMPLE) begin
            o_module_rst_b <= 1'b1;
            o_memory_rst_b <= 1'b1;
            o_clock_power_rst_b <= 1'b1;
        end else if (in_run) begin
            // system reset keeps memory and clocks running
            o_module_rst_b <= ~(i_max_rst_req | i_sys_rst_req);
            o_memory_rst_b <= ~i_max_rst_req; // max acts as warm
        end
    end
end

endmodule

// file: tb/rspm_strap_board.sv
/* rspm_strap_board.sv: strap resistors of the board on the async address pads.
   assumes the device lets go of the pads whenever it is not sampling straps. */
`timescale 1ns/1ps
module rspm_strap_board (
    input wire i_clk,
    input wire i_strap_sample,
    input wire i_fitted,
    input wire [5:0] i_strap,
    output reg [13:0] o_pads
);
    reg [13:0] junk = 14'h2aaa;
    // released pads toggle between 2aaa and 1555 each cycle, so a late sample reads a value that depends on the sampling edge
    always @(posedge i_clk) begin
        junk <= ~junk;
    end
    // no resistors fitted: the internal pulls give boot 00 and code 1101
    always @* begin
        o_pads = i_strap_sample ? {(i_fitted ? i_strap : 6'h0d), 8'h00} : junk;
    end
endmodule

// file: tb/rspm_asserts.sv
/* rspm_asserts.sv: concurrent checks on the ports of rspm_top.
   assumes one clock domain and attachment through the bind at the foot. */
`timescale 1ns/1ps
module rspm_asserts #(
    parameter NMOD = 41
) (
    input wire i_clk, input wire i_rst_b, input wire i_max_rst_req, input wire i_sys_rst_req,
    input wire [NMOD-1:0] i_mod_rst_req,
    input wire i_mux_wr, input wire [2:0] i_mux_sel, input wire [31:0] i_mux_wdata,
    input wire [1:0] o_boot_source_select, input wire [3:0] o_async_pin_config_code,
    input wire o_cfg_valid, input wire o_strap_sample,
    input wire o_top_pad_mem, input wire o_top_pad_is_a14,
    input wire [13:0] o_async_addr_line_mem, input wire [7:0] o_async_data_line_hi_mem,
    input wire [31:0] o_async_mem_mux_reg, input wire [2:0] o_reset_kind,
    input wire o_module_rst_b, input wire o_memory_rst_b,
    input wire o_emulation_rst_b, input wire o_clock_power_rst_b,
    input wire [NMOD-1:0] o_mod_rst_b
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    a_top_pad_a14: assert property (o_top_pad_is_a14 |-> o_top_pad_mem)
        else $error("top pad is a14 but not a memory pin");
    a_ale_cle_kept: assert property (o_async_addr_line_mem[2:1] == 2'h3)
        else $error("address lines 1 and 2 left memory function");
    a_strap_release: assert property ($rose(o_cfg_valid) |-> !o_strap_sample
        && o_async_mem_mux_reg[3:0] == o_async_pin_config_code)
        else $error("pads not released or mux reg not loaded from straps");
    a_cfg_hold: assert property (o_cfg_valid && $past(o_cfg_valid) |->
        $stable(o_boot_source_select) && $stable(o_async_pin_config_code))
        else $error("latched straps changed");
    a_mux_write: assert property (o_cfg_valid && i_mux_wr && i_mux_sel == 3'h2
        && !i_max_rst_req |=> o_async_mem_mux_reg == $past(i_mux_wdata))
        else $error("async mux write not taken");
    a_wide_data: assert property (o_cfg_valid && $changed(o_async_mem_mux_reg)
        && o_async_mem_mux_reg[3:0] == 4'h0 |=> o_async_data_line_hi_mem == 8'hff)
        else $error("upper data byte not enabled for code 0000");
    a_max_warm: assert property (o_cfg_valid && i_max_rst_req |=> o_reset_kind == 3'h3
        && !o_module_rst_b && !o_memory_rst_b && o_emulation_rst_b && !o_cfg_valid)
        else $error("max reset differs from warm reset");
    a_sys_soft: assert property (o_cfg_valid && i_sys_rst_req && !i_max_rst_req |=>
        o_reset_kind == 3'h4 && !o_module_rst_b && o_memory_rst_b && o_clock_power_rst_b)
        else $error("system reset touched memory or clocks");
    a_mod_only: assert property (o_cfg_valid && i_mod_rst_req != 0 && !i_max_rst_req
        && !i_sys_rst_req |=> o_reset_kind == 3'h5 && o_mod_rst_b == ~$past(i_mod_rst_req))
        else $error("module reset not routed to its module");
    c_max: cover property (o_cfg_valid && i_max_rst_req);
    c_sys: cover property (o_cfg_valid && i_sys_rst_req);
    c_wide: cover property (o_async_data_line_hi_mem == 8'hff);
endmodule
bind rspm_top rspm_asserts #(.NMOD(NMOD)) u_chk (.*);

// file: tb/tb.sv
/* tb.sv: self-checking bench for rspm_top with the strap board model.
   assumes rspm_top, rspm_asserts and rspm_strap_board are compiled first. */
`timescale 1ns/1ps
module tb;
    localparam [23:0] CODES = 24'hdca820;
    reg i_clk, i_rst_b, i_test_rst_b, i_max_rst_req, i_sys_rst_req, i_mux_wr, i_boot_progress;
    reg [40:0] i_mod_rst_req;
    reg [2:0] i_mux_sel;
    reg [31:0] i_mux_wdata;
    reg [5:0] strap;
    reg fitted;
    wire [13:0] i_async_addr_line, o_async_addr_line_mem;
    wire [1:0] o_boot_source_select;
    wire [3:0] o_async_pin_config_code;
    wire [2:0] o_reset_kind;
    wire [7:0] o_async_data_line_hi_mem;
    wire [40:0] o_mod_rst_b;
    wire [31:0] o_video_in_mux_reg, o_video_out_mux_reg, o_async_mem_mux_reg, o_gpio_mux_reg;
    wire [31:0] o_serial_card_mux_reg;
    wire o_cfg_valid, o_boot_progress_pin, o_boot_progress_pin_oe_b, o_use_first_chip_select;
    wire o_use_first_serial_port, o_use_first_card_controller, o_boot_from_rom, o_strap_sample;
    wire o_async_bank_addr_line1_mem, o_top_pad_mem, o_top_pad_is_a14, o_module_rst_b;
    wire o_memory_rst_b, o_emulation_rst_b, o_clock_power_rst_b;
    integer n_fail, checks_done, i;
    rspm_top #(.NMOD(41)) u_dut (.*);
    rspm_strap_board u_board (.i_clk(i_clk), .i_strap_sample(o_strap_sample),
        .i_fitted(fitted), .i_strap(strap), .o_pads(i_async_addr_line));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input [63:0] exp, input [63:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task pads(input [3:0] c);
        begin
            chk("async mux code", c, o_async_mem_mux_reg[3:0]);
            chk("addr pads", (c != 4'hd) ? 14'h3fff : 14'h0006, o_async_addr_line_mem);
            chk("bank addr 1", c != 4'hd, o_async_bank_addr_line1_mem);
            chk("top pad", {c == 4'ha || c == 4'h2, c != 4'hd && c != 4'hc},
                {o_top_pad_is_a14, o_top_pad_mem});
            chk("data hi", (c == 4'h2 || c == 4'h0) ? 8'hff : 8'h00, o_async_data_line_hi_mem);
        end
    endtask
    // unfitted straps fall back to the pull defaults
    task boot(input [5:0] st, input fit, input tst);
        reg [5:0] e;
        begin
            e = fit ? st : 6'h0d;
            @(posedge i_clk);
            i_rst_b <= 1'b0;
            strap <= st;
            fitted <= fit;
            i_test_rst_b <= tst;
            repeat (10) @(posedge i_clk);
            @(negedge i_clk);
            chk("in reset", {4'h3, 2'h0, tst, 1'b0}, {o_reset_kind, o_strap_sample,
                o_module_rst_b, o_memory_rst_b,
                o_emulation_rst_b, o_clock_power_rst_b});
            @(posedge i_clk);
            i_rst_b <= 1'b1;
            repeat (4) @(posedge i_clk);
            @(negedge i_clk);
            chk("reset kind", tst ? 3'h2 : 3'h1, o_reset_kind);
            chk("released", 4'hf, {o_module_rst_b, o_memory_rst_b, o_emulation_rst_b,
                o_clock_power_rst_b});
            chk("straps", e, {o_boot_source_select, o_async_pin_config_code});
            chk("routing", {e[5:4] == 2'h1, e[5:4] <= 2'h1, e[5:4] == 2'h0, e[5:4] == 2'h2,
                e[5:4] != 2'h1}, {o_boot_progress_pin_oe_b, o_use_first_chip_select,
                o_use_first_serial_port, o_use_first_card_controller, o_boot_from_rom});
            pads(e[3:0]);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #3000000;
        n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        n_fail = 0;
        checks_done = 0;
        {i_rst_b, i_test_rst_b, i_max_rst_req, i_sys_rst_req, i_mux_wr} = 5'h0;
        {i_boot_progress, i_mod_rst_req, i_mux_sel, i_mux_wdata, strap, fitted} = 0;
        boot(6'h00, 1'b0, 1'b0);
        for (i = 0; i < 6; i = i + 1) begin
            boot({i[1:0], CODES[i*4 +: 4]}, 1'b1, i[0]);
        end
        // back-to-back writes, with the async mux last and an unmapped select between
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge i_clk);
            i_mux_wr <= 1'b1;
            i_mux_sel <= (i == 5) ? 3'h2 : (i == 2) ? 3'h5 : i[2:0];
            i_mux_wdata <= (i == 5) ? 32'h0 : 32'h5a5a0000 | i;
        end
        @(posedge i_clk);
        i_mux_wr <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk("mux regs", {32'h5a5a0000, 32'h5a5a0001}, {o_video_in_mux_reg, o_video_out_mux_reg});
        chk("mux regs", {32'h5a5a0003, 32'h5a5a0004}, {o_gpio_mux_reg, o_serial_card_mux_reg});
        chk("strap code kept", 4'hd, o_async_pin_config_code);
        pads(4'h0);
        @(posedge i_clk);
        i_max_rst_req <= 1'b1;
        @(posedge i_clk);
        i_max_rst_req <= 1'b0;
        @(negedge i_clk);
        chk("max reset", 6'h19, {o_reset_kind, o_module_rst_b, o_memory_rst_b, o_emulation_rst_b});
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("mux after max", 32'h0, o_video_in_mux_reg);
        pads(4'hd);
        @(posedge i_clk);
        i_sys_rst_req <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("system reset", 7'h47, {o_reset_kind, o_module_rst_b, o_memory_rst_b,
            o_clock_power_rst_b, o_emulation_rst_b});
        @(posedge i_clk);
        i_sys_rst_req <= 1'b0;
        i_mod_rst_req <= 41'h20;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("module reset", {3'h5, ~41'h20}, {o_reset_kind, o_mod_rst_b});
        @(posedge i_clk);
        i_mod_rst_req <= 41'h0;
        i_boot_progress <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("boot progress", 2'h3, {o_boot_progress_pin, o_boot_progress_pin_oe_b});
        complete_run;
    end
endmodule
